// ### rtl/sc_wait_timers.sv
// Smart card wait timers: guard spacing, block/work, character and answer-to-reset timeouts.
// Assumes the card I/O line arrives unsynchronised, and that transmitter and
// receiver pulse their start-of-character strobes on this clock.
`timescale 1ns/100ps
module sc_wait_timers
  import sc_wait_pkg::*;
#(
  parameter int DIV_WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_card_io,
  input wire logic i_card_reset_n,
  input wire logic i_rx_start,
  input wire logic i_tx_request,
  input wire logic i_tx_last,
  input wire logic i_break_detect,
  output logic o_tx_allow,
  output logic o_irq
);
  logic [7:0] guard_high_ff;
  logic [7:0] guard_low_ff;
  logic [3:0] bw3_ff;
  logic [7:0] bw2_ff;
  logic [7:0] bw1_ff;
  logic [7:0] bw0_ff;
  logic [7:0] cw_high_ff;
  logic [7:0] cw_low_ff;
  logic [7:0] atr_high_ff;
  logic [7:0] atr_low_ff;
  logic [7:0] first_to_ff;
  logic [7:0] rst_len_ff;
  logic [2:0] ctrl_ff;
  logic [IRQ_BITS-1:0] status_ff;
  logic [IRQ_BITS-1:0] mask_ff;
  logic [DIV_WIDTH-1:0] div_ff;
  logic io_meta_ff;
  logic io_sync_ff;
  logic io_prev_ff;
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_prev_ff;
  logic etu_tick;
  logic rx_edge;
  logic reset_release;
  logic is_t1;
  logic [8:0] guard_prog;
  logic [8:0] guard_eff;
  logic [8:0] guard_cnt_ff;
  logic guard_busy_ff;
  logic break_hold_ff;
  logic tx_start;
  logic [27:0] block_wait;
  logic bw_run_ff;
  logic bw_restart;
  logic bw_expired;
  logic cw_run_ff;
  logic cw_expired;
  logic atr_run_ff;
  logic atr_started_ff;
  logic atr_expired;
  logic ts_run_ff;
  logic ts_expired;
  logic [IRQ_BITS-1:0] events;
  logic wr_hit_status;

  // Card I/O and card reset pins pass two flops before anything looks at them.
  // Both start at their released levels, so no false edge follows a system reset.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      io_meta_ff <= 1'b1;
      io_sync_ff <= 1'b1;
      io_prev_ff <= 1'b1;
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= 1'b1;
      rst_prev_ff <= 1'b1;
    end else begin
      io_meta_ff <= i_card_io;
      io_sync_ff <= io_meta_ff;
      io_prev_ff <= io_sync_ff;
      rst_meta_ff <= i_card_reset_n;
      rst_sync_ff <= rst_meta_ff;
      rst_prev_ff <= rst_sync_ff;
    end
  end

  // A received start bit is the receiver's strobe or a falling edge on the line.
  assign rx_edge = i_rx_start || (io_prev_ff && !io_sync_ff);
  assign reset_release = rst_sync_ff && !rst_prev_ff;
  assign is_t1 = ctrl_ff[CTRL_T1_POS];

  etu_divider #(
    .WIDTH(DIV_WIDTH)
  ) u_div (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_restart(tx_start),
    .i_div(div_ff),
    .o_tick(etu_tick)
  );

  // Register writes.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      guard_high_ff <= RST_GUARD_HIGH;
      guard_low_ff <= RST_EXTRA_GUARD_LOW;
      bw3_ff <= '0;
      bw2_ff <= RST_ZERO;
      bw1_ff <= RST_ZERO;
      bw0_ff <= RST_ZERO;
      cw_high_ff <= RST_ZERO;
      cw_low_ff <= RST_ZERO;
      atr_high_ff <= RST_ZERO;
      atr_low_ff <= RST_ZERO;
      first_to_ff <= RST_ZERO;
      rst_len_ff <= RST_CARD_RESET_LENGTH;
      ctrl_ff <= '0;
      mask_ff <= '0;
      div_ff <= RST_ETU_DIV[DIV_WIDTH-1:0];
    end else if (i_wr) begin
      case (i_addr)
        ADDR_GUARD_HIGH: guard_high_ff <= i_wdata;
        ADDR_EXTRA_GUARD_LOW: guard_low_ff <= i_wdata;
        ADDR_BLOCK_WAIT_BYTE3: bw3_ff <= i_wdata[BW_TOP_BITS-1:0];
        ADDR_BLOCK_WAIT_BYTE2: bw2_ff <= i_wdata;
        ADDR_BLOCK_WAIT_BYTE1: bw1_ff <= i_wdata;
        ADDR_BLOCK_WAIT_BYTE0: bw0_ff <= i_wdata;
        ADDR_CHAR_WAIT_HIGH: cw_high_ff <= i_wdata;
        ADDR_CHAR_WAIT_LOW: cw_low_ff <= i_wdata;
        ADDR_ANSWER_TIMEOUT_HIGH: atr_high_ff <= i_wdata;
        ADDR_ANSWER_TIMEOUT_LOW: atr_low_ff <= i_wdata;
        ADDR_FIRST_CHAR_TIMEOUT: first_to_ff <= i_wdata;
        ADDR_CARD_RESET_LENGTH: rst_len_ff <= i_wdata;
        ADDR_CONTROL: ctrl_ff <= i_wdata[2:0];
        ADDR_IRQ_MASK: mask_ff <= i_wdata[IRQ_BITS-1:0];
        ADDR_ETU_DIV_LOW: div_ff[7:0] <= i_wdata;
        ADDR_ETU_DIV_HIGH: div_ff[DIV_WIDTH-1:8] <= i_wdata[DIV_WIDTH-9:0];
        default: ;
      endcase
    end
  end

  // Register reads, data in the cycle after the strobe.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_GUARD_HIGH: o_rdata <= guard_high_ff;
        ADDR_EXTRA_GUARD_LOW: o_rdata <= guard_low_ff;
        ADDR_BLOCK_WAIT_BYTE3: o_rdata <= {4'h0, bw3_ff};
        ADDR_BLOCK_WAIT_BYTE2: o_rdata <= bw2_ff;
        ADDR_BLOCK_WAIT_BYTE1: o_rdata <= bw1_ff;
        ADDR_BLOCK_WAIT_BYTE0: o_rdata <= bw0_ff;
        ADDR_CHAR_WAIT_HIGH: o_rdata <= cw_high_ff;
        ADDR_CHAR_WAIT_LOW: o_rdata <= cw_low_ff;
        ADDR_ANSWER_TIMEOUT_HIGH: o_rdata <= atr_high_ff;
        ADDR_ANSWER_TIMEOUT_LOW: o_rdata <= atr_low_ff;
        ADDR_FIRST_CHAR_TIMEOUT: o_rdata <= first_to_ff;
        ADDR_CARD_RESET_LENGTH: o_rdata <= rst_len_ff;
        ADDR_CONTROL: o_rdata <= {5'h00, ctrl_ff};
        ADDR_IRQ_STATUS: o_rdata <= {5'h00, status_ff};
        ADDR_IRQ_MASK: o_rdata <= {5'h00, mask_ff};
        ADDR_ETU_DIV_LOW: o_rdata <= div_ff[7:0];
        ADDR_ETU_DIV_HIGH: o_rdata <= div_ff[DIV_WIDTH-1:8];
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Guard spacing between transmitted start edges. The ETU restarts at each start and the
  // count starts at zero, so a full guard time always passes before the next start.
  assign guard_prog = {guard_high_ff[GUARD_MSB_POS], guard_low_ff};
  always_comb begin
    guard_eff = guard_prog;
    if (is_t1 && guard_prog < GUARD_MIN_T1) begin
      guard_eff = GUARD_MIN_T1;
    end else if (!is_t1 && guard_prog < GUARD_MIN_T0) begin
      guard_eff = GUARD_MIN_T0;
    end
  end
  assign tx_start = i_tx_request && o_tx_allow;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      break_hold_ff <= 1'b0;
    end else if (tx_start) begin
      break_hold_ff <= 1'b0;
    end else if (!is_t1 && i_break_detect) begin
      break_hold_ff <= 1'b1;
    end else if (!i_break_detect) begin
      break_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      guard_cnt_ff <= '0;
      guard_busy_ff <= 1'b0;
      o_tx_allow <= 1'b0;
    end else begin
      if (tx_start) begin
        guard_cnt_ff <= 9'h000;
        guard_busy_ff <= 1'b1;
      end else if (guard_busy_ff && etu_tick) begin
        guard_cnt_ff <= guard_cnt_ff + 9'h001;
        if (guard_cnt_ff + 9'h001 >= guard_eff) begin
          guard_busy_ff <= 1'b0;
        end
      end
      o_tx_allow <= !tx_start && !(guard_busy_ff && !(etu_tick
        && guard_cnt_ff + 9'h001 >= guard_eff)) && !(break_hold_ff || i_break_detect);
    end
  end

  // Block wait (T=1) or work wait (T=0) supervision.
  assign block_wait = {bw3_ff, bw2_ff, bw1_ff, bw0_ff};
  assign bw_restart = tx_start || (!is_t1 && rx_edge);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bw_run_ff <= 1'b0;
    end else if (is_t1) begin
      if (tx_start) begin
        bw_run_ff <= 1'b1;
      end else if (rx_edge || bw_expired) begin
        bw_run_ff <= 1'b0;
      end
    end else if (tx_start || rx_edge) begin
      bw_run_ff <= 1'b1;
    end else if (bw_expired) begin
      bw_run_ff <= 1'b0;
    end
  end

  etu_timer #(
    .WIDTH(28)
  ) u_block_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(bw_run_ff),
    .i_restart(bw_restart),
    .i_tick(etu_tick),
    .i_limit(block_wait),
    .o_expired(bw_expired)
  );

  // Received character spacing, character or initial wait.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cw_run_ff <= 1'b0;
    end else if (rx_edge) begin
      cw_run_ff <= 1'b1;
    end else if (cw_expired || tx_start) begin
      cw_run_ff <= 1'b0;
    end
  end

  etu_timer #(
    .WIDTH(16)
  ) u_char_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(cw_run_ff),
    .i_restart(rx_edge),
    .i_tick(etu_tick),
    .i_limit({cw_high_ff, cw_low_ff}),
    .o_expired(cw_expired)
  );

  // Answer-to-reset duration, armed by the flag, started by the first start bit.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !ctrl_ff[CTRL_RCV_POS]) begin
      atr_started_ff <= 1'b0;
      atr_run_ff <= 1'b0;
    end else if (rx_edge && !atr_started_ff) begin
      atr_started_ff <= 1'b1;
      atr_run_ff <= 1'b1;
    end else if (atr_expired) begin
      atr_run_ff <= 1'b0;
    end
  end

  etu_timer #(
    .WIDTH(16)
  ) u_atr_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(atr_run_ff),
    .i_restart(1'b0),
    .i_tick(etu_tick),
    .i_limit({atr_high_ff, atr_low_ff}),
    .o_expired(atr_expired)
  );

  // First character timer from card reset release.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !ctrl_ff[CTRL_DET_POS]) begin
      ts_run_ff <= 1'b0;
    end else if (reset_release) begin
      ts_run_ff <= 1'b1;
    end else if (rx_edge || ts_expired || !rst_sync_ff) begin
      ts_run_ff <= 1'b0;
    end
  end

  etu_timer #(
    .WIDTH(8)
  ) u_ts_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(ts_run_ff),
    .i_restart(reset_release),
    .i_tick(etu_tick),
    .i_limit(first_to_ff),
    .o_expired(ts_expired)
  );

  // Sticky status; a read clears it, a coincident event still sets it.
  assign events[IRQ_WAIT_POS] = bw_expired;
  assign events[IRQ_CHAR_POS] = cw_expired;
  assign events[IRQ_ATR_POS] = atr_expired || ts_expired;
  assign wr_hit_status = i_rd && i_addr == ADDR_IRQ_STATUS;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      status_ff <= '0;
    end else begin
      status_ff <= (wr_hit_status ? '0 : status_ff) | events;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((wr_hit_status ? '0 : status_ff) | events) & mask_ff);
    end
  end
endmodule : sc_wait_timers

// ### rtl/sc_wait_pkg.sv
// Package for the smart card wait timers: register offsets, reset values, widths.
// Assumes a byte-wide register port with 16-bit addresses.
package sc_wait_pkg;
  localparam logic [15:0] ADDR_GUARD_HIGH = 16'hFE16;
  localparam logic [15:0] ADDR_EXTRA_GUARD_LOW = 16'hFE17;
  localparam logic [15:0] ADDR_BLOCK_WAIT_BYTE3 = 16'hFE18;
  localparam logic [15:0] ADDR_BLOCK_WAIT_BYTE2 = 16'hFE19;
  localparam logic [15:0] ADDR_BLOCK_WAIT_BYTE1 = 16'hFE1A;
  localparam logic [15:0] ADDR_BLOCK_WAIT_BYTE0 = 16'hFE1B;
  localparam logic [15:0] ADDR_CHAR_WAIT_HIGH = 16'hFE1C;
  localparam logic [15:0] ADDR_CHAR_WAIT_LOW = 16'hFE1D;
  localparam logic [15:0] ADDR_ANSWER_TIMEOUT_HIGH = 16'hFE1F;
  localparam logic [15:0] ADDR_ANSWER_TIMEOUT_LOW = 16'hFE20;
  localparam logic [15:0] ADDR_FIRST_CHAR_TIMEOUT = 16'hFE21;
  localparam logic [15:0] ADDR_CARD_RESET_LENGTH = 16'hFE22;
  localparam logic [15:0] ADDR_CONTROL = 16'hFE30;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFE31;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hFE32;
  localparam logic [15:0] ADDR_ETU_DIV_LOW = 16'hFE33;
  localparam logic [15:0] ADDR_ETU_DIV_HIGH = 16'hFE34;
  localparam logic [7:0] RST_GUARD_HIGH = 8'h00;
  localparam logic [7:0] RST_EXTRA_GUARD_LOW = 8'h0C;
  localparam logic [7:0] RST_CARD_RESET_LENGTH = 8'h70;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [15:0] RST_ETU_DIV = 16'h0174;
  localparam logic [8:0] GUARD_MIN_T0 = 9'h00C;
  localparam logic [8:0] GUARD_MIN_T1 = 9'h00B;
  localparam int GUARD_MSB_POS = 7;
  localparam int BW_TOP_BITS = 4;
  localparam int CTRL_T1_POS = 0;
  localparam int CTRL_RCV_POS = 1;
  localparam int CTRL_DET_POS = 2;
  localparam int IRQ_WAIT_POS = 0;
  localparam int IRQ_CHAR_POS = 1;
  localparam int IRQ_ATR_POS = 2;
  localparam int IRQ_BITS = 3;
endpackage : sc_wait_pkg

// ### rtl/etu_divider.sv
// ETU divider: one-cycle enable every div system clocks.
// Assumes div is stable during use; a zero divisor acts as one.
`timescale 1ns/100ps
module etu_divider #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_restart,
  input wire logic [WIDTH-1:0] i_div,
  output logic o_tick
);
  logic [WIDTH-1:0] cnt_ff;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_restart) begin
      cnt_ff <= '0;
      o_tick <= 1'b0;
    end else if (cnt_ff + 1'b1 >= i_div) begin
      cnt_ff <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule : etu_divider

// ### rtl/etu_timer.sv
// Saturating ETU counter with restart and an expiry pulse above the limit.
// Assumes i_tick is a one-cycle enable from the ETU divider.
`timescale 1ns/100ps
module etu_timer #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic i_tick,
  input wire logic [WIDTH-1:0] i_limit,
  output logic o_expired
);
  logic [WIDTH-1:0] cnt_ff;
  logic done_ff;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_run || i_restart) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
      o_expired <= 1'b0;
    end else begin
      o_expired <= 1'b0;
      if (i_tick && !done_ff) begin
        if (cnt_ff >= i_limit) begin
          done_ff <= 1'b1;
          o_expired <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end
endmodule : etu_timer

// ### tb/sc_wait_timers_assertions.sv
// Checker for the smart card wait timers: relations between the block's ports over time.
// Assumes it is bound to sc_wait_timers and sees only that module's ports.
`timescale 1ns/100ps
module sc_wait_checker
  import sc_wait_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_tx_request,
  input wire logic i_break_detect,
  input wire logic o_tx_allow,
  input wire logic o_irq
);
  default clocking dcb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Clock cycles since the last transmitted start, saturating at the top.
  logic [7:0] gap_ff;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      gap_ff <= 8'hFF;
    end else if (i_tx_request && o_tx_allow) begin
      gap_ff <= 8'h00;
    end else if (gap_ff != 8'hFF) begin
      gap_ff <= gap_ff + 8'h01;
    end
  end
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data present without a read");
  byte3_top_a: assert property (i_rd && i_addr == ADDR_BLOCK_WAIT_BYTE3 |=> o_rdata[7:4] == 4'h0)
    else $error("block wait top byte shows upper bits");
  tx_drop_a: assert property (i_tx_request && o_tx_allow |=> !o_tx_allow)
    else $error("transmit allow stayed high after a start");
  guard_floor_a: assert property ($rose(o_tx_allow) |-> gap_ff >= 8'h0C)
    else $error("transmit allow returned before the guard floor");
  allow_hold_a: assert property (o_tx_allow && !i_tx_request && !i_break_detect |=> o_tx_allow)
    else $error("transmit allow dropped without a start");
  break_hold_a: assert property (i_break_detect [*2] |-> !o_tx_allow)
    else $error("transmit allowed during a break");
  reset_state_a: assert property ($fell(i_sys_rst) |-> !o_tx_allow && !o_irq ##1 o_tx_allow)
    else $error("outputs wrong after reset release");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(i_rd) || $past(i_rd, 2)
    || $past(i_wr) || $past(i_wr, 2))
    else $error("interrupt dropped without a register access");
endmodule : sc_wait_checker

// ### tb/sc_card_model.sv
// Smart card model: sends one character on the card I/O line each time i_go is raised.
// Assumes a pull-up holds the line high while the card is silent.
`timescale 1ns/100ps
module sc_card_model #(
  parameter int ETU = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_go,
  output logic o_io
);
  logic [15:0] left_ff;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      left_ff <= 16'h0000;
    end else if (i_go) begin
      left_ff <= 16'(10 * ETU);
    end else if (left_ff != 16'h0000) begin
      left_ff <= left_ff - 16'h0001;
    end
  end
  // The start bit is low for one ETU; the rest of the frame stays high to avoid false edges.
  assign o_io = left_ff <= 16'(9 * ETU);
endmodule : sc_card_model

// ### tb/smartcard_wait_timers_bench.sv
// Testbench for the smart card wait timers: registers, guard spacing and timeouts.
// Assumes a 40 MHz clock and an ETU divider programmed to four clocks.
`timescale 1ns/100ps
module smartcard_wait_timers_bench
  import sc_wait_pkg::*;
;
  localparam int D = 4;
  logic i_clk, i_sys_rst, i_wr, i_rd, i_card_reset_n, i_rx_start, i_tx_request;
  logic i_break_detect, o_tx_allow, o_irq, card_io, go, rd_d;
  logic [15:0] i_addr, a;
  logic [7:0] i_wdata, o_rdata, v;
  logic [15:0] notes[$];
  int fails = 0;
  int checked = 0;
  int n;
  int seed = 32'h5c9c;

  sc_wait_timers sc_wait_timers_i (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_card_io(card_io), .i_card_reset_n, .i_rx_start, .i_tx_request,
    .i_tx_last(1'b0), .i_break_detect, .o_tx_allow, .o_irq);
  sc_card_model #(.ETU(D)) sc_card_model_i (.i_clk, .i_sys_rst, .i_go(go), .o_io(card_io));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  always @(posedge i_clk) rd_d <= i_rd;
  always @(negedge i_clk) begin
    if (rd_d) begin
      check("read data", o_rdata & notes[0][15:8], notes[0][7:0]);
      void'(notes.pop_front());
    end
  end

  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    i_addr <= ad;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [15:0] ad, input logic [7:0] e, input logic [7:0] m);
    notes.push_back({m, e & m});
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask : rd

  task automatic wait_allow(output int c);
    c = 0;
    do begin
      @(negedge i_clk);
      c++;
    end while (o_tx_allow !== 1'b1 && c < 3000);
    if (c >= 3000) begin
      fails++;
      summarize();
    end
    @(posedge i_clk);
  endtask : wait_allow

  task automatic tx_start;
    int t;
    wait_allow(t);
    i_tx_request <= 1'b1;
    @(posedge i_clk);
    i_tx_request <= 1'b0;
  endtask : tx_start

  task automatic look_irq(input logic e);
    @(negedge i_clk);
    check("irq", {7'h00, o_irq}, {7'h00, e});
    @(posedge i_clk);
  endtask : look_irq

  task automatic guard(input logic [7:0] ctl, input logic [7:0] hi, input logic [7:0] lo,
                       input int g);
    wr(ADDR_CONTROL, ctl);
    wr(ADDR_GUARD_HIGH, hi);
    wr(ADDR_EXTRA_GUARD_LOW, lo);
    tx_start();
    wait_allow(n);
    check("guard short", {7'h00, n >= g * D}, 8'h01);
    check("guard long", {7'h00, n <= g * D + D + 2}, 8'h01);
    $display("guard case done");
  endtask : guard

  // Kinds: 0 transmitted start, 1 card character, 2 card reset release, 3 receiver strobe.
  task automatic tmo(input logic [7:0] ctl, input logic [15:0] la, input logic [15:0] lim,
                     input int k, input logic [7:0] b, input logic [7:0] m);
    wr(ADDR_CONTROL, ctl);
    wr(la, lim[15:8]);
    wr(la + 16'h0001, lim[7:0]);
    wr(ADDR_IRQ_MASK, m);
    case (k)
      0: tx_start();
      1: go <= 1'b1;
      2: i_card_reset_n <= 1'b0;
      default: i_rx_start <= 1'b1;
    endcase
    repeat (D) @(posedge i_clk);
    go <= 1'b0;
    i_card_reset_n <= 1'b1;
    i_rx_start <= 1'b0;
    rd(ADDR_IRQ_STATUS, 8'h00, 8'h00);
    repeat ((lim - 3) * D) @(posedge i_clk);
    rd(ADDR_IRQ_STATUS, 8'h00, b);
    repeat (6 * D) @(posedge i_clk);
    look_irq((b & m) != 8'h00);
    rd(ADDR_IRQ_STATUS, b, b);
    repeat (3) @(posedge i_clk);
    look_irq(1'b0);
    $display("timeout case done");
  endtask : tmo

  initial begin
    i_sys_rst = 1'b1;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_card_reset_n = 1'b1;
    i_rx_start = 1'b0;
    i_tx_request = 1'b0;
    i_break_detect = 1'b0;
    go = 1'b0;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    for (int i = 0; i < 13; i++) begin
      a = ADDR_GUARD_HIGH + 16'(i);
      v = (a == ADDR_CARD_RESET_LENGTH) ? RST_CARD_RESET_LENGTH : RST_ZERO;
      rd(a, (a == ADDR_EXTRA_GUARD_LOW) ? RST_EXTRA_GUARD_LOW : v, 8'hFF);
    end
    rd(ADDR_ETU_DIV_LOW, RST_ETU_DIV[7:0], 8'hFF);
    wr(ADDR_ETU_DIV_LOW, 8'(D));
    wr(ADDR_ETU_DIV_HIGH, 8'h00);
    for (int i = 1; i < 13; i++) begin
      a = ADDR_GUARD_HIGH + 16'(i);
      v = 8'($random(seed));
      wr(a, v);
      rd(a, (a == 16'hFE1E) ? 8'h00 : (a == ADDR_BLOCK_WAIT_BYTE3) ? v & 8'h0F : v, 8'hFF);
      wr(a, 8'h00);
    end
    $display("register case done");
    guard(8'h00, 8'h00, 8'h02, 12);
    guard(8'h01, 8'h00, 8'h02, 11);
    guard(8'h00, 8'h80, 8'h14, 276);
    wr(ADDR_GUARD_HIGH, 8'h00);
    guard(8'h00, 8'h00, 8'h00, 12);
    tx_start();
    i_break_detect <= 1'b1;
    repeat (20 * D) @(posedge i_clk);
    @(negedge i_clk);
    check("allow in break", {7'h00, o_tx_allow}, 8'h00);
    @(posedge i_clk);
    i_break_detect <= 1'b0;
    wait_allow(n);
    $display("break case done");
    tmo(8'h01, ADDR_BLOCK_WAIT_BYTE1, 16'h0006, 0, 8'h01, 8'h01);
    tmo(8'h00, ADDR_BLOCK_WAIT_BYTE1, 16'h0006, 3, 8'h01, 8'h01);
    tmo(8'h01, ADDR_CHAR_WAIT_HIGH, 16'h0006, 1, 8'h02, 8'h02);
    tmo(8'h02, ADDR_ANSWER_TIMEOUT_HIGH, 16'h0006, 1, 8'h04, 8'h04);
    tmo(8'h04, ADDR_ANSWER_TIMEOUT_LOW, 16'h0006, 2, 8'h04, 8'h00);
    repeat (4) @(posedge i_clk);
    summarize();
  end
endmodule : smartcard_wait_timers_bench

bind sc_wait_timers sc_wait_checker sc_wait_checker_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_request(i_tx_request),
  .i_break_detect(i_break_detect), .o_tx_allow(o_tx_allow), .o_irq(o_irq));
